//--- bench/buck_boost_clamp_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module buck_boost_clamp_control_bench;
  logic mclk = 1'b0, rst_b = 1'b0, ce = 1'b1, limit_wdata = 1'b0;
  logic conv_sel_we = 1'b0, arm_we = 1'b0, mode_we = 1'b0;
  logic limit_we = 1'b0, status_clr_we = 1'b0;
  logic [3:0] conv_sel_wdata = 4'h0, arm_chan_sel = 4'h0;
  logic [3:0] pos_floor_wdata = 4'h0, neg_floor_wdata = 4'h0;
  logic [3:0] mode_chan_sel = 4'h0, limit_chan_sel = 4'h0;
  logic [3:0] current_mode = 4'h0, load_sense_done = 4'h0;
  logic [3:0] status_clr_data = 4'h0;
  logic [1:0] arm_wdata = 2'h0, mode_wdata = 2'h0;
  logic [11:0] range_code = 12'h000;
  logic [15:0] load_sense_level = 16'h0000;
  logic [39:0] rail_feedback_dv = 40'h0;
  wire [3:0] conv_selected, pos_arm_enable, neg_arm_enable;
  wire [3:0] neg_rail_to_ground, high_side_limit_select, load_sense_start;
  wire [3:0] learn_done_flag, rail_max_alarm;
  wire [7:0] clamp_mode_select;
  wire [15:0] positive_rail_floor_level, negative_rail_floor_level;
  wire [39:0] pos_rail_target_dv, neg_rail_target_dv, pos_rail_max_dv;
  int bad_count = 0, samples_checked = 0, cyc = 0, n;

  buck_boost_clamp_control dut_u (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .conv_sel_we(conv_sel_we),
    .conv_sel_wdata(conv_sel_wdata),
    .arm_we(arm_we),
    .arm_chan_sel(arm_chan_sel),
    .arm_wdata(arm_wdata),
    .pos_floor_wdata(pos_floor_wdata),
    .neg_floor_wdata(neg_floor_wdata),
    .mode_we(mode_we),
    .mode_chan_sel(mode_chan_sel),
    .mode_wdata(mode_wdata),
    .limit_we(limit_we),
    .limit_chan_sel(limit_chan_sel),
    .limit_wdata(limit_wdata),
    .current_mode(current_mode),
    .range_code(range_code),
    .load_sense_done(load_sense_done),
    .load_sense_level(load_sense_level),
    .rail_feedback_dv(rail_feedback_dv),
    .status_clr_we(status_clr_we),
    .status_clr_data(status_clr_data),
    .conv_selected(conv_selected),
    .pos_arm_enable(pos_arm_enable),
    .neg_arm_enable(neg_arm_enable),
    .neg_rail_to_ground(neg_rail_to_ground),
    .clamp_mode_select(clamp_mode_select),
    .positive_rail_floor_level(positive_rail_floor_level),
    .negative_rail_floor_level(negative_rail_floor_level),
    .high_side_limit_select(high_side_limit_select),
    .pos_rail_target_dv(pos_rail_target_dv),
    .neg_rail_target_dv(neg_rail_target_dv),
    .pos_rail_max_dv(pos_rail_max_dv),
    .load_sense_start(load_sense_start),
    .learn_done_flag(learn_done_flag),
    .rail_max_alarm(rail_max_alarm)
  );

  always #10 mclk = ~mclk;

  // cuts a hung run short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: run timed out", $time);
      tally_and_finish;
    end
  end

  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one strobe cycle: bits pick select, arm, mode, limit, clear
  task wr(input logic [4:0] w);
    @(negedge mclk);
    {status_clr_we, limit_we, mode_we, arm_we, conv_sel_we} = w;
    @(negedge mclk);
    {status_clr_we, limit_we, mode_we, arm_we, conv_sel_we} = 5'h00;
  endtask

  task tick(input int k);
    repeat (k) @(negedge mclk);
  endtask

  // waits a bounded time for channel 3 sensing to start
  task wait_start;
    n = 0;
    while (load_sense_start[3] !== 1'b1 && n < 80) begin
      @(negedge mclk);
      n++;
    end
  endtask

  initial begin
    tick(3);
    rst_b = 1'b1;
    chk(clamp_mode_select, 8'h00);
    chk(neg_rail_to_ground, 4'hf);
    chk(pos_rail_max_dv, {4{10'h140}});
    $display("reset test ends");
    // several converter subsets, ending with all four
    for (n = 0; n < 16; n += 5) begin
      conv_sel_wdata = n[3:0];
      wr(5'h01);
      chk(conv_selected, n[3:0]);
    end
    // clock enable low freezes the select register
    ce = 1'b0;
    conv_sel_wdata = 4'h0;
    wr(5'h01);
    chk(conv_selected, 4'hf);
    ce = 1'b1;
    arm_chan_sel = 4'h5;
    arm_wdata = 2'h1;
    wr(5'h02);
    arm_chan_sel = 4'ha;
    arm_wdata = 2'h3;
    pos_floor_wdata = 4'h3;
    neg_floor_wdata = 4'h2;
    wr(5'h02);
    tick(1);
    chk(pos_arm_enable, 4'hf);
    chk(neg_arm_enable, 4'ha);
    chk(neg_rail_to_ground, 4'h5);
    chk(positive_rail_floor_level, 16'h3030);
    chk(negative_rail_floor_level, 16'h2020);
    chk(pos_rail_target_dv[19:10], 10'h096);
    chk(neg_rail_target_dv[19:10], 10'h096);
    $display("arm test ends");
    // current output with a bipolar range on channel 1
    current_mode = 4'hf;
    range_code = 12'h038;
    tick(2);
    chk(pos_rail_target_dv[39:30], 10'h028);
    chk(neg_rail_target_dv[19:10], 10'h028);
    chk(neg_rail_target_dv[39:30], 10'h000);
    mode_chan_sel = 4'h2;
    mode_wdata = 2'h1;
    wr(5'h04);
    tick(1);
    chk(pos_rail_target_dv[19:10], 10'h064);
    mode_wdata = 2'h3;
    wr(5'h04);
    tick(1);
    chk(pos_rail_target_dv[19:10], 10'h028);
    $display("mode test ends");
    // lower ceiling on channel 1 only, then alarm at the ceiling
    limit_chan_sel = 4'h2;
    limit_wdata = 1'b1;
    wr(5'h08);
    tick(1);
    chk(high_side_limit_select, 4'h2);
    chk(pos_rail_max_dv, {10'h140, 10'h140, 10'h104, 10'h140});
    rail_feedback_dv = {10'h13f, 10'h000, 10'h104, 10'h000};
    tick(2);
    chk(rail_max_alarm, 4'h2);
    rail_feedback_dv = {10'h000, 10'h000, 10'h103, 10'h140};
    tick(2);
    chk(rail_max_alarm, 4'h1);
    $display("limit test ends");
    // learn on channel 3, floor write refused meanwhile
    mode_chan_sel = 4'h8;
    mode_wdata = 2'h2;
    wr(5'h04);
    arm_chan_sel = 4'h8;
    pos_floor_wdata = 4'hf;
    wr(5'h02);
    chk(positive_rail_floor_level[15:12], 4'h3);
    wait_start;
    chk(n < 80, 1'b1);
    load_sense_level = 16'h5000;
    load_sense_done = 4'h8;
    tick(1);
    load_sense_done = 4'h0;
    chk(positive_rail_floor_level[15:12], 4'h5);
    chk(learn_done_flag, 4'h8);
    tick(3);
    chk(pos_rail_target_dv[39:30], 10'h08c);
    chk(learn_done_flag, 4'h8);
    status_clr_data = 4'h8;
    wr(5'h10);
    chk(learn_done_flag, 4'h0);
    wr(5'h04);
    wait_start;
    chk(n < 80, 1'b1);
    mode_wdata = 2'h0;
    wr(5'h04);
    $display("learn test ends");
    tally_and_finish;
  end
endmodule
`default_nettype wire

//--- bench/clamp_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// watches write echo, learn sequencing, status and rail ceilings
module clamp_monitor (
  input wire logic mclk, // clock
  input wire logic rst_b, // reset, low
  input wire logic ce, // enable
  input wire logic conv_sel_we, // select write
  input wire logic [3:0] conv_sel_wdata, // select data
  input wire logic arm_we, // arm write
  input wire logic [3:0] arm_chan_sel, // arm channels
  input wire logic mode_we, // mode write
  input wire logic [3:0] mode_chan_sel, // mode channels
  input wire logic [1:0] mode_wdata, // mode data
  input wire logic [3:0] load_sense_done, // sensing done
  input wire logic [15:0] load_sense_level, // sensed levels
  input wire logic status_clr_we, // clear write
  input wire logic [3:0] status_clr_data, // clear bits
  input wire logic [3:0] conv_selected, // selected
  input wire logic [3:0] neg_arm_enable, // negative arms
  input wire logic [3:0] neg_rail_to_ground, // ground ties
  input wire logic [7:0] clamp_mode_select, // modes
  input wire logic [15:0] positive_rail_floor_level, // floors
  input wire logic [3:0] high_side_limit_select, // limits
  input wire logic [39:0] pos_rail_max_dv, // ceilings
  input wire logic [3:0] load_sense_start, // sensing start
  input wire logic [3:0] learn_done_flag // learn status
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // learn request and flag clear on channel 3
  wire learn_req;
  wire clr3;
  wire learning3;
  assign learn_req = ce && mode_we && mode_chan_sel[3] && mode_wdata == 2'h2;
  assign clr3 = ce && status_clr_we && status_clr_data[3];
  assign learning3 = clamp_mode_select[7:6] == 2'h2;
  a_sel_echo: assert property (ce && conv_sel_we |=>
    conv_selected == $past(conv_sel_wdata)) else $error("select lost");
  a_ground_tie: assert property ($past(ce) |->
    neg_rail_to_ground == ~($past(conv_selected) & $past(neg_arm_enable)))
    else $error("ground tie");
  a_settle_wait: assert property (learn_req |=>
    !load_sense_start[3] [*8] ##[36:52] load_sense_start[3])
    else $error("sensing start timing");
  a_start_once: assert property (load_sense_start[3] |=>
    !load_sense_start[3]) else $error("start not a pulse");
  a_floor_locked: assert property (learning3 && ce && arm_we &&
    arm_chan_sel[3] && !load_sense_done[3] && !mode_we |=>
    $stable(positive_rail_floor_level[15:12])) else $error("floor changed");
  a_learn_store: assert property (learning3 && ce && load_sense_done[3] |=>
    positive_rail_floor_level[15:12] == $past(load_sense_level[15:12]) &&
    learn_done_flag[3]) else $error("learned level lost");
  a_flag_sticky: assert property (learn_done_flag[3] && !clr3 |=>
    learn_done_flag[3]) else $error("flag dropped");
  a_max_ceiling: assert property ($past(ce) |-> pos_rail_max_dv[19:10] ==
    ($past(high_side_limit_select[1]) ? 10'h104 : 10'h140))
    else $error("ceiling wrong");
  // main scenarios reached
  cover property (learn_req);
  cover property (learn_done_flag[3]);
  cover property (high_side_limit_select[1]);
endmodule
bind buck_boost_clamp_control clamp_monitor mon_u (
  .mclk(mclk),
  .rst_b(rst_b),
  .ce(ce),
  .conv_sel_we(conv_sel_we),
  .conv_sel_wdata(conv_sel_wdata),
  .arm_we(arm_we),
  .arm_chan_sel(arm_chan_sel),
  .mode_we(mode_we),
  .mode_chan_sel(mode_chan_sel),
  .mode_wdata(mode_wdata),
  .load_sense_done(load_sense_done),
  .load_sense_level(load_sense_level),
  .status_clr_we(status_clr_we),
  .status_clr_data(status_clr_data),
  .conv_selected(conv_selected),
  .neg_arm_enable(neg_arm_enable),
  .neg_rail_to_ground(neg_rail_to_ground),
  .clamp_mode_select(clamp_mode_select),
  .positive_rail_floor_level(positive_rail_floor_level),
  .high_side_limit_select(high_side_limit_select),
  .pos_rail_max_dv(pos_rail_max_dv),
  .load_sense_start(load_sense_start),
  .learn_done_flag(learn_done_flag)
);
`default_nettype wire

//--- rtl/buck_boost_clamp_control.v
`timescale 1ns/10ps
`default_nettype none
`include "buck_boost_clamp_regs.vh"

// Summary of operation
// - host selects any subset of converters
// - positive and negative arms enabled separately
// - disabled negative arm ties rail to ground
// - voltage mode targets fixed symmetric 15 V rails outside fixed clamp mode
// - current mode negative rail follows range setting
// - reset mode is full tracking, 4 V floor
// - fixed mode floors come from level fields
// - learn mode senses load, fixes floor
// - learned level stored; done flag set in the same cycle unless a mode write hits that channel
// - positive level read-only while learning
// - rewriting learn mode restarts sensing
// - max rail 32 V, limit bit gives 26 V
// - limit bit applies to selected channels
// - alarm when positive rail hits maximum
// - learn done flags stay until host writes one; rail max alarm follows the rail each cycle
module buck_boost_clamp_control (
  input wire mclk, // 50 MHz clock
  input wire rst_b, // synchronous reset, active low
  input wire ce, // clock enable
  input wire conv_sel_we, // write strobe, converter select
  input wire [3:0] conv_sel_wdata, // converter select bits
  input wire arm_we, // write strobe, arm and clamp levels
  input wire [3:0] arm_chan_sel, // channels this arm write applies to
  input wire [1:0] arm_wdata, // bit0 positive, bit1 negative arm
  input wire [3:0] pos_floor_wdata, // positive rail floor level
  input wire [3:0] neg_floor_wdata, // negative rail floor level
  input wire mode_we, // write strobe, clamp mode
  input wire [3:0] mode_chan_sel, // channels this mode write applies to
  input wire [1:0] mode_wdata, // clamp mode value
  input wire limit_we, // write strobe, high side limit
  input wire [3:0] limit_chan_sel, // channel selection field
  input wire limit_wdata, // high side limit value
  input wire [3:0] current_mode, // per channel: 1 current, 0 voltage
  input wire [11:0] range_code, // 3-bit output range per channel
  input wire [3:0] load_sense_done, // per channel sensing complete
  input wire [15:0] load_sense_level, // 4-bit learned level per channel
  input wire [39:0] rail_feedback_dv, // 10-bit positive rail per channel
  input wire status_clr_we, // write strobe, status clear
  input wire [3:0] status_clr_data, // one clears learn flag per channel
  output reg [3:0] conv_selected, // converter select readback
  output reg [3:0] pos_arm_enable, // positive arm enables
  output reg [3:0] neg_arm_enable, // negative arm enables
  output reg [3:0] neg_rail_to_ground, // negative rail tied to ground
  output reg [7:0] clamp_mode_select, // 2 bits per channel
  output reg [15:0] positive_rail_floor_level, // 4 bits per channel
  output reg [15:0] negative_rail_floor_level, // 4 bits per channel
  output reg [3:0] high_side_limit_select, // per channel limit bit
  output reg [39:0] pos_rail_target_dv, // positive floor, tenths of V
  output reg [39:0] neg_rail_target_dv, // negative magnitude, tenths
  output reg [39:0] pos_rail_max_dv, // positive ceiling, tenths of V
  output reg [3:0] load_sense_start, // one-cycle start of sensing
  output reg [3:0] learn_done_flag, // sticky learn complete status
  output reg [3:0] rail_max_alarm // positive rail at its maximum
);
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_SETTLE = 3'h2;
  localparam [2:0] ST_SENSE = 3'h4;
  localparam integer SETTLE_INT = `LEARN_SETTLE_CYC;
  localparam [5:0] SETTLE_CYC = SETTLE_INT[5:0];

  reg [2:0] state [0:3];
  reg [5:0] settle_cnt [0:3];
  reg [3:0] mem_we_hold;
  reg [1:0] mem_waddr;
  reg [3:0] mem_wdata;
  reg [1:0] mem_raddr;
  wire [3:0] mem_rdata;
  integer i;
  integer j;
  integer k;

  // effective mode: spare code folds into tracking
  function [1:0] eff_mode;
    input [1:0] m;
    begin
      if (m == `CLAMP_MODE_SPARE) begin
        eff_mode = `CLAMP_MODE_TRACK;
      end else begin
        eff_mode = m;
      end
    end
  endfunction

  // floor level to tenths of a volt
  function [9:0] level_dv;
    input [3:0] lvl;
    begin
      level_dv = `RAIL_TRACK_FLOOR_DV + {6'h0, lvl} * `RAIL_STEP_DV;
    end
  endfunction

  // copy of last learned level per channel, lowest channel only when several finish together; read port fixed on channel 0, rdata unused
  channel_level_store u_learn_store (
    .mclk(mclk),
    .ce(ce),
    .we(|mem_we_hold),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // pick the lowest channel finishing learn this cycle for the store
  always @* begin
    mem_we_hold = 4'h0;
    mem_waddr = 2'h0;
    mem_wdata = 4'h0;
    mem_raddr = 2'h0;
    for (j = 3; j >= 0; j = j - 1) begin
      if (state[j] == ST_SENSE && load_sense_done[j]) begin
        mem_we_hold = 4'h1;
        mem_waddr = j[1:0];
        mem_wdata = load_sense_level[j*4 +: 4];
      end
    end
  end

  // configuration registers and learn sequencing
  always @(posedge mclk) begin
    if (!rst_b) begin
      conv_selected <= 4'h0;
      pos_arm_enable <= 4'h0;
      neg_arm_enable <= 4'h0;
      clamp_mode_select <= {4{`CLAMP_MODE_RESET}};
      positive_rail_floor_level <= {4{`FLOOR_LEVEL_RESET}};
      negative_rail_floor_level <= {4{`FLOOR_LEVEL_RESET}};
      high_side_limit_select <= 4'h0;
      load_sense_start <= 4'h0;
      learn_done_flag <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        state[i] <= ST_IDLE;
        settle_cnt[i] <= 6'h0;
      end
    end else if (ce) begin
      if (conv_sel_we) begin
        conv_selected <= conv_sel_wdata;
      end
      load_sense_start <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        if (arm_we && arm_chan_sel[i]) begin
          pos_arm_enable[i] <= arm_wdata[`ARM_POS_BIT];
          neg_arm_enable[i] <= arm_wdata[`ARM_NEG_BIT];
          negative_rail_floor_level[i*4 +: 4] <= neg_floor_wdata;
          if (eff_mode(clamp_mode_select[i*2 +: 2]) !=
              `CLAMP_MODE_LEARN) begin
            positive_rail_floor_level[i*4 +: 4] <= pos_floor_wdata;
          end
        end
        if (limit_we && limit_chan_sel[i]) begin
          high_side_limit_select[i] <= limit_wdata;
        end
        // learn sequence per channel
        case (state[i])
          ST_IDLE: begin
          end
          ST_SETTLE: begin
            if (settle_cnt[i] == 6'h0) begin
              load_sense_start[i] <= 1'b1;
              state[i] <= ST_SENSE;
            end else begin
              settle_cnt[i] <= settle_cnt[i] - 6'h1;
            end
          end
          ST_SENSE: begin
            if (load_sense_done[i]) begin
              positive_rail_floor_level[i*4 +: 4] <=
                load_sense_level[i*4 +: 4];
              state[i] <= ST_IDLE;
            end
          end
          default: begin
            state[i] <= ST_IDLE;
          end
        endcase
        if (mode_we && mode_chan_sel[i]) begin
          clamp_mode_select[i*2 +: 2] <= mode_wdata;
          if (mode_wdata == `CLAMP_MODE_LEARN) begin
            state[i] <= ST_SETTLE;
            settle_cnt[i] <= SETTLE_CYC - 6'h1;
          end else begin
            state[i] <= ST_IDLE;
          end
        end
        if (state[i] == ST_SENSE && load_sense_done[i] &&
            !(mode_we && mode_chan_sel[i])) begin
          learn_done_flag[i] <= 1'b1;
        end else if (status_clr_we && status_clr_data[i]) begin
          learn_done_flag[i] <= 1'b0;
        end
      end
    end
  end

  // rail targets, ceilings, ground tie and alarm
  always @(posedge mclk) begin
    if (!rst_b) begin
      neg_rail_to_ground <= 4'hf;
      pos_rail_target_dv <= 40'h0;
      neg_rail_target_dv <= 40'h0;
      pos_rail_max_dv <= {4{`RAIL_MAX_DV}};
      rail_max_alarm <= 4'h0;
    end else if (ce) begin
      for (k = 0; k < 4; k = k + 1) begin
        neg_rail_to_ground[k] <= !(conv_selected[k] && neg_arm_enable[k]);
        pos_rail_max_dv[k*10 +: 10] <= high_side_limit_select[k] ?
          `RAIL_MAX_LIMITED_DV : `RAIL_MAX_DV;
        rail_max_alarm[k] <= conv_selected[k] && pos_arm_enable[k] &&
          (rail_feedback_dv[k*10 +: 10] >= pos_rail_max_dv[k*10 +: 10]);
        // voltage output ignores tracking: only the fixed clamp overrides
        if (!(conv_selected[k] && pos_arm_enable[k])) begin
          pos_rail_target_dv[k*10 +: 10] <= 10'h0;
        end else if (!current_mode[k]) begin
          pos_rail_target_dv[k*10 +: 10] <=
            (clamp_mode_select[k*2 +: 2] == `CLAMP_MODE_FIXED) ?
            level_dv(positive_rail_floor_level[k*4 +: 4]) : `RAIL_VOUT_DV;
        end else if (eff_mode(clamp_mode_select[k*2 +: 2]) ==
                     `CLAMP_MODE_TRACK) begin
          pos_rail_target_dv[k*10 +: 10] <= `RAIL_TRACK_FLOOR_DV;
        end else begin
          pos_rail_target_dv[k*10 +: 10] <=
            level_dv(positive_rail_floor_level[k*4 +: 4]);
        end
        if (!(conv_selected[k] && neg_arm_enable[k])) begin
          neg_rail_target_dv[k*10 +: 10] <= 10'h0;
        end else if (current_mode[k]) begin
          neg_rail_target_dv[k*10 +: 10] <=
            (range_code[k*3 +: 3] == `RANGE_BIPOLAR) ?
            `RAIL_TRACK_FLOOR_DV : 10'h0;
        end else if (clamp_mode_select[k*2 +: 2] == `CLAMP_MODE_FIXED) begin
          neg_rail_target_dv[k*10 +: 10] <=
            level_dv(negative_rail_floor_level[k*4 +: 4]);
        end else begin
          neg_rail_target_dv[k*10 +: 10] <= `RAIL_VOUT_DV;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/buck_boost_clamp_regs.vh
`ifndef BUCK_BOOST_CLAMP_REGS_VH
`define BUCK_BOOST_CLAMP_REGS_VH
// clamp mode codes
`define CLAMP_MODE_TRACK 2'h0
`define CLAMP_MODE_FIXED 2'h1
`define CLAMP_MODE_LEARN 2'h2
`define CLAMP_MODE_SPARE 2'h3
// arm enable bit positions within the 2-bit arm write data
`define ARM_POS_BIT 0
`define ARM_NEG_BIT 1
// reset values
`define CLAMP_MODE_RESET 2'h0
`define FLOOR_LEVEL_RESET 4'h0
// rail figures in tenths of a volt
`define RAIL_TRACK_FLOOR_DV 10'h028
`define RAIL_VOUT_DV 10'h096
`define RAIL_MAX_DV 10'h140
`define RAIL_MAX_LIMITED_DV 10'h104
`define RAIL_STEP_DV 10'h014
// current range code for bipolar output
`define RANGE_BIPOLAR 3'h7
// learn settle time in ns and cycles at 50 MHz
`define LEARN_SETTLE_NS 1000
`define CLK_PERIOD_NS 20
`define LEARN_SETTLE_CYC ((`LEARN_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

//--- rtl/channel_level_store.v
`timescale 1ns/10ps
`default_nettype none
// small per-channel store of 4-bit levels, registered read port
module channel_level_store (
  input wire mclk, // clock
  input wire ce, // clock enable
  input wire we, // write strobe
  input wire [1:0] waddr, // write channel
  input wire [3:0] wdata, // write level
  input wire [1:0] raddr, // read channel
  output reg [3:0] rdata // registered read level
);
  reg [3:0] mem [0:3];

  // write and registered read
  always @(posedge mclk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire
